/* common/tick_if.sv */
`timescale 1ns/10ps
interface tick_if;
	logic tick;
	logic hold;
	modport src (output tick, input hold);
	modport snk (input tick, output hold);
endinterface

/* common/wdg_pkg.sv */
package wdg_pkg;

	// ---------------------------------------------
	// register map
	// ---------------------------------------------
	localparam int         ADDR_W      = 8;
	localparam logic [9:0] CTRL_INDEX  = 10'h02a;
	localparam logic [7:0] CTRL_ADDR   = 8'(CTRL_INDEX << 2);
	localparam logic [7:0] CTRL_RESET  = 8'h7f;
	localparam int         ACT_BIT     = 7;
	localparam int         TOP_BIT     = 6;
	localparam logic [1:0] RESP_OK     = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ---------------------------------------------
	// timing
	// ---------------------------------------------
	localparam int DIV_DEFAULT    = 16384;
	localparam int CLK_MHZ        = 50;
	localparam int RST_PULSE_NS   = 500;
	localparam int RST_PULSE_CYC  = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int WAKE_SHORT_CYC = 256;
	localparam int WAKE_LONG_CYC  = 4096;
	localparam int PULSE_W        = $clog2(RST_PULSE_CYC);
	localparam int DLY_W          = $clog2(WAKE_LONG_CYC);

	// ---------------------------------------------
	// states
	// ---------------------------------------------
	typedef enum logic [5:0] {
		ST_RUN       = 6'h01,
		ST_HALT_DEC  = 6'h02,
		ST_HALT_STOP = 6'h04,
		ST_ACT_HALT  = 6'h08,
		ST_DELAY     = 6'h10,
		ST_FIRE      = 6'h20
	} state_t;

endpackage

/* src/wdg_prescaler.sv */
`timescale 1ns/10ps
module wdg_prescaler #(
	parameter int DIV = wdg_pkg::DIV_DEFAULT
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// tick towards the counter
	tick_if.src      tk
);
	localparam int         W       = $clog2(DIV);
	localparam logic [W-1:0] LAST  = W'(DIV - 1);

	logic [W-1:0] div_ff;

	// not cleared by a register write, so the first period after a refresh varies
	always_ff @(posedge clk) begin
		if (reset) begin
			div_ff  <= '0;
			tk.tick <= 1'b0;
		end else if (ce) begin
			if (tk.hold) begin
				tk.tick <= 1'b0;
			end else if (div_ff == LAST) begin
				div_ff  <= '0;
				tk.tick <= 1'b1;
			end else begin
				div_ff  <= div_ff + 1'b1;
				tk.tick <= 1'b0;
			end
		end
	end

	AST_TICK_SPACING: assert property (@(posedge clk) disable iff (reset || !ce)
		tk.tick |-> div_ff == '0)
		else $error("tick without prescaler wrap");

endmodule

/* src/wdg_top.sv */
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
module wdg_top #(
	parameter int DIV = wdg_pkg::DIV_DEFAULT
) (
	// clock, reset, enable
	input  wire logic                       CLK,
	input  wire logic                       RESET,
	input  wire logic                       CE,
	// avalon-mm slave, byte address
	input  wire logic [wdg_pkg::ADDR_W-1:0] ADDRESS,
	input  wire logic                       READ,
	input  wire logic                       WRITE,
	input  wire logic [31:0]                WRITEDATA,
	input  wire logic [3:0]                 BYTEENABLE,
	output logic      [31:0]                READDATA,
	output logic                            WAITREQUEST,
	output logic      [1:0]                 RESPONSE,
	// halt control and options
	input  wire logic                       HALT_EXEC,
	input  wire logic                       RTC_IRQ_ENABLE,
	input  wire logic                       HALT_RESET_OPTION,
	input  wire logic                       HW_WATCHDOG,
	input  wire logic                       WAKE_DELAY_LONG,
	input  wire logic                       EXT_IRQ_WAKE,
	input  wire logic                       OSC_IRQ_WAKE,
	// status
	output logic                            RESET_PIN_N,
	output logic                            HALTED
);
	localparam logic [wdg_pkg::PULSE_W-1:0] PULSE_LAST = wdg_pkg::PULSE_W'(wdg_pkg::RST_PULSE_CYC - 1);
	localparam logic [wdg_pkg::DLY_W-1:0]   DLY_SHORT  = wdg_pkg::DLY_W'(wdg_pkg::WAKE_SHORT_CYC - 1);
	localparam logic [wdg_pkg::DLY_W-1:0]   DLY_LONG   = wdg_pkg::DLY_W'(wdg_pkg::WAKE_LONG_CYC - 1);

	wdg_pkg::state_t               state_ff;
	wdg_pkg::state_t               nxt_state;
	logic [6:0]                    cnt_ff;
	logic                          activate_bit_ff;
	logic [wdg_pkg::PULSE_W-1:0]   pulse_ff;
	logic [wdg_pkg::DLY_W-1:0]     dly_ff;
	logic                          countdown_top_bit;
	logic                          armed;
	logic                          trig;
	logic                          pulse_done;
	logic                          dly_done;
	logic                          hit;
	logic                          wr_take;
	logic                          tick;

	tick_if tk ();

	wdg_prescaler #(
		.DIV (DIV)
	) u_prescaler (
		.clk   (CLK),
		.reset (RESET),
		.ce    (CE),
		.tk    (tk.src)
	);

	assign tick              = tk.tick;
	assign countdown_top_bit = cnt_ff[wdg_pkg::TOP_BIT];
	assign armed             = activate_bit_ff | HW_WATCHDOG;
	assign trig              = armed && !countdown_top_bit;
	assign pulse_done        = pulse_ff == PULSE_LAST;
	assign dly_done          = dly_ff == (WAKE_DELAY_LONG ? DLY_LONG : DLY_SHORT);
	assign hit               = ADDRESS == wdg_pkg::CTRL_ADDR;
	assign wr_take           = WRITE && !WAITREQUEST && hit && BYTEENABLE[0];

	// prescaler only runs where the counter may step
	assign tk.hold = !(state_ff == wdg_pkg::ST_RUN || state_ff == wdg_pkg::ST_HALT_DEC);

	// ---------------------------------------------
	// bus slave
	// ---------------------------------------------
	// one wait state: answer lands at the second edge, write takes effect there
	always_ff @(posedge CLK) begin
		if (RESET) begin
			WAITREQUEST <= 1'b1;
			READDATA    <= 32'h0;
			RESPONSE    <= wdg_pkg::RESP_OK;
		end else if (CE) begin
			if ((READ || WRITE) && WAITREQUEST) begin
				WAITREQUEST <= 1'b0;
				RESPONSE    <= hit ? wdg_pkg::RESP_OK : wdg_pkg::RESP_DECERR;
				READDATA    <= (READ && hit) ? {24'h0, activate_bit_ff, cnt_ff} : 32'h0;
			end else begin
				WAITREQUEST <= 1'b1;
			end
		end
	end

	// ---------------------------------------------
	// control register
	// ---------------------------------------------
	always_ff @(posedge CLK) begin
		if (RESET) begin
			cnt_ff          <= wdg_pkg::CTRL_RESET[6:0];
			activate_bit_ff <= wdg_pkg::CTRL_RESET[wdg_pkg::ACT_BIT];
		end else if (CE) begin
			if (state_ff == wdg_pkg::ST_FIRE && pulse_done) begin
				// our own reset puts the control register back to its reset image
				cnt_ff          <= wdg_pkg::CTRL_RESET[6:0];
				activate_bit_ff <= wdg_pkg::CTRL_RESET[wdg_pkg::ACT_BIT];
			end else if (wr_take) begin
				cnt_ff <= WRITEDATA[6:0];
				if (WRITEDATA[wdg_pkg::ACT_BIT]) begin
					activate_bit_ff <= 1'b1;
				end
			end else if (tick && (state_ff == wdg_pkg::ST_RUN || state_ff == wdg_pkg::ST_HALT_DEC)) begin
				cnt_ff <= cnt_ff - 7'h01;
			end
		end
	end

	// ---------------------------------------------
	// mode sequencer
	// ---------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			wdg_pkg::ST_RUN: begin
				if (trig) begin
					nxt_state = wdg_pkg::ST_FIRE;
				end else if (HALT_EXEC) begin
					if (RTC_IRQ_ENABLE) begin
						nxt_state = wdg_pkg::ST_ACT_HALT;
					end else if (HALT_RESET_OPTION) begin
						nxt_state = wdg_pkg::ST_FIRE;
					end else begin
						nxt_state = wdg_pkg::ST_HALT_DEC;
					end
				end
			end
			wdg_pkg::ST_HALT_DEC: begin
				if (EXT_IRQ_WAKE) begin
					nxt_state = wdg_pkg::ST_DELAY;
				end else if (tick) begin
					nxt_state = wdg_pkg::ST_HALT_STOP;
				end
			end
			wdg_pkg::ST_HALT_STOP: begin
				if (EXT_IRQ_WAKE) begin
					nxt_state = wdg_pkg::ST_DELAY;
				end
			end
			wdg_pkg::ST_ACT_HALT: begin
				if (OSC_IRQ_WAKE || EXT_IRQ_WAKE) begin
					nxt_state = wdg_pkg::ST_RUN;
				end
			end
			wdg_pkg::ST_DELAY: begin
				if (dly_done) begin
					nxt_state = wdg_pkg::ST_RUN;
				end
			end
			wdg_pkg::ST_FIRE: begin
				if (pulse_done) begin
					nxt_state = wdg_pkg::ST_DELAY;
				end
			end
			default: begin
				nxt_state = wdg_pkg::ST_DELAY;
			end
		endcase
	end

	// any reset, from the pin or our own, is followed by the restart delay
	always_ff @(posedge CLK) begin
		if (RESET) begin
			state_ff <= wdg_pkg::ST_DELAY;
		end else if (CE) begin
			state_ff <= nxt_state;
		end
	end

	// ---------------------------------------------
	// restart delay and reset pulse timers
	// ---------------------------------------------
	always_ff @(posedge CLK) begin
		if (RESET) begin
			dly_ff <= '0;
		end else if (CE) begin
			if (state_ff == wdg_pkg::ST_DELAY && !dly_done) begin
				dly_ff <= dly_ff + 1'b1;
			end else begin
				dly_ff <= '0;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			pulse_ff <= '0;
		end else if (CE) begin
			if (state_ff == wdg_pkg::ST_FIRE && !pulse_done) begin
				pulse_ff <= pulse_ff + 1'b1;
			end else begin
				pulse_ff <= '0;
			end
		end
	end

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	always_ff @(posedge CLK) begin
		if (RESET) begin
			RESET_PIN_N <= 1'b1;
			HALTED      <= 1'b0;
		end else if (CE) begin
			RESET_PIN_N <= nxt_state != wdg_pkg::ST_FIRE;
			HALTED      <= nxt_state == wdg_pkg::ST_HALT_DEC || nxt_state == wdg_pkg::ST_HALT_STOP
				|| nxt_state == wdg_pkg::ST_ACT_HALT;
		end
	end

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET || !CE);

	sequence s_fire_pulse;
		!RESET_PIN_N [*8] ##17 !RESET_PIN_N ##1 RESET_PIN_N;
	endsequence

	sequence s_halt_wake;
		state_ff == wdg_pkg::ST_HALT_STOP && EXT_IRQ_WAKE;
	endsequence

	sequence s_restart_wait;
		state_ff == wdg_pkg::ST_DELAY [*8] ##1 state_ff == wdg_pkg::ST_DELAY;
	endsequence

	AST_PULSE_LENGTH: assert property ($fell(RESET_PIN_N) |-> s_fire_pulse)
		else $error("reset pulse length wrong");

	AST_TOP_BIT_FIRES: assert property (state_ff == wdg_pkg::ST_RUN && activate_bit_ff && !countdown_top_bit
		|=> state_ff == wdg_pkg::ST_FIRE)
		else $error("armed rollover did not reset");

	AST_ACT_STICKY: assert property (activate_bit_ff && state_ff != wdg_pkg::ST_FIRE |=> activate_bit_ff)
		else $error("activate bit cleared without reset");

	AST_INACTIVE_SILENT: assert property (state_ff == wdg_pkg::ST_RUN && !armed && !HALT_EXEC
		|=> state_ff != wdg_pkg::ST_FIRE)
		else $error("reset while not activated");

	AST_RESET_IMAGE: assert property (@(posedge CLK) disable iff (1'b0)
		$fell(RESET) |-> cnt_ff == wdg_pkg::CTRL_RESET[6:0] && !activate_bit_ff)
		else $error("control register reset value wrong");

	AST_HW_OPTION: assert property (state_ff == wdg_pkg::ST_RUN && HW_WATCHDOG && !countdown_top_bit
		|=> state_ff == wdg_pkg::ST_FIRE)
		else $error("hardware option did not reset");

	AST_HALT_STOPS: assert property (state_ff == wdg_pkg::ST_HALT_STOP && !EXT_IRQ_WAKE
		|=> $stable(cnt_ff) && RESET_PIN_N && HALTED)
		else $error("counter moved after halt step");

	AST_HALT_WAKE_DELAY: assert property (s_halt_wake |=> s_restart_wait ##1 $stable(cnt_ff))
		else $error("counting resumed too early after halt");

	AST_HALT_OPTION_RESET: assert property (state_ff == wdg_pkg::ST_RUN && HALT_EXEC && !RTC_IRQ_ENABLE
		&& HALT_RESET_OPTION |=> !RESET_PIN_N)
		else $error("halt option did not reset");

	AST_ACTIVE_HALT_FROZEN: assert property (state_ff == wdg_pkg::ST_ACT_HALT && !wr_take
		|=> $stable(cnt_ff) && RESET_PIN_N)
		else $error("counter moved in active halt");

	AST_ACTIVE_HALT_EXIT: assert property (state_ff == wdg_pkg::ST_ACT_HALT && OSC_IRQ_WAKE
		|=> state_ff == wdg_pkg::ST_RUN && !HALTED)
		else $error("active halt exit not immediate");

	AST_FREE_RUN: assert property (state_ff == wdg_pkg::ST_RUN && tick && !wr_take && !armed
		|=> cnt_ff == $past(cnt_ff) - 7'h01)
		else $error("free running step missing");

	AST_WRITE_LOAD: assert property (wr_take && state_ff != wdg_pkg::ST_FIRE
		|=> cnt_ff == $past(WRITEDATA[6:0]) && (activate_bit_ff || !$past(WRITEDATA[7])))
		else $error("write did not load control register");

endmodule

/* verification/tb.sv */
`timescale 1ns/10ps
module tb;
	// ---------------------------------------------
	// stimulus and observation
	// ---------------------------------------------
	localparam int DIV = 16;
	logic        CLK, RESET, CE, READ, WRITE, HALT_EXEC, RTC_IRQ_ENABLE, HALT_RESET_OPTION;
	logic        HW_WATCHDOG, WAKE_DELAY_LONG, EXT_IRQ_WAKE, OSC_IRQ_WAKE, WAITREQUEST, RESET_PIN_N, HALTED;
	logic [7:0]  ADDRESS;
	logic [31:0] WRITEDATA, READDATA, q, q2;
	logic [3:0]  BYTEENABLE;
	logic [1:0]  RESPONSE, resp;
	logic [31:0] seed, r;
	int          bad_count, checks_done, lows;

	wdg_top #(.DIV(DIV)) wdg_top_i (.CLK(CLK), .RESET(RESET), .CE(CE), .ADDRESS(ADDRESS), .READ(READ),
		.WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
		.WAITREQUEST(WAITREQUEST), .RESPONSE(RESPONSE), .HALT_EXEC(HALT_EXEC), .RTC_IRQ_ENABLE(RTC_IRQ_ENABLE),
		.HALT_RESET_OPTION(HALT_RESET_OPTION), .HW_WATCHDOG(HW_WATCHDOG), .WAKE_DELAY_LONG(WAKE_DELAY_LONG),
		.EXT_IRQ_WAKE(EXT_IRQ_WAKE), .OSC_IRQ_WAKE(OSC_IRQ_WAKE), .RESET_PIN_N(RESET_PIN_N), .HALTED(HALTED));

	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge CLK);
		ADDRESS <= a;
		WRITEDATA <= {24'h0, d};
		WRITE <= w;
		READ <= !w;
		@(negedge CLK);
		// only the bench watchdog ends a wait
		while (WAITREQUEST !== 1'b0) begin
			@(negedge CLK);
			n++;
		end
		@(posedge CLK);
		q = READDATA;
		resp = RESPONSE;
		READ <= 1'b0;
		WRITE <= 1'b0;
		chk("bus_wait", 1, n);
	endtask

	// one-cycle strobe on {halt, osc wake, ext wake}
	task automatic pulse(input logic [2:0] sel);
		@(posedge CLK);
		{HALT_EXEC, OSC_IRQ_WAKE, EXT_IRQ_WAKE} <= sel;
		@(posedge CLK);
		{HALT_EXEC, OSC_IRQ_WAKE, EXT_IRQ_WAKE} <= 3'b000;
	endtask

	task automatic idle(input int n);
		lows = 0;
		repeat (n) begin
			@(negedge CLK);
			if (RESET_PIN_N !== 1'b1) lows++;
		end
	endtask

	// fire time window, pulse length, then room for the short restart delay
	task automatic fire(input int lo, input int hi);
		int n;
		int m;
		n = 0;
		m = 1;
		while (RESET_PIN_N !== 1'b0 && n <= hi) begin
			@(negedge CLK);
			n++;
		end
		chk("fire_time", 1, 32'(n >= lo && n <= hi));
		while (RESET_PIN_N === 1'b0 && m < 100) begin
			@(negedge CLK);
			m++;
		end
		chk("pulse_len", wdg_pkg::RST_PULSE_CYC, m - 1);
		repeat (wdg_pkg::WAKE_SHORT_CYC + 20) @(posedge CLK);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ---------------------------------------------
	// clock, reset, watchdog
	// ---------------------------------------------
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end

	initial begin
		repeat (30000) @(posedge CLK);
		bad_count++;
		stop_test();
	end

	// ---------------------------------------------
	// scenarios
	// ---------------------------------------------
	initial begin
		{RESET, CE, BYTEENABLE} = {1'b1, 1'b1, 4'hf};
		{READ, WRITE, HALT_EXEC, RTC_IRQ_ENABLE, HALT_RESET_OPTION} = 5'h00;
		{HW_WATCHDOG, WAKE_DELAY_LONG, EXT_IRQ_WAKE, OSC_IRQ_WAKE} = 4'h0;
		{ADDRESS, WRITEDATA, bad_count, checks_done} = '0;
		seed = 32'h0000d932;
		repeat (5) @(posedge CLK);
		RESET <= 1'b0;
		bus(1'b0, wdg_pkg::CTRL_ADDR, 8'h00);
		chk("ctrl_reset", 32'h7f, q);
		bus(1'b0, 8'h00, 8'h00);
		chk("unmapped_resp", wdg_pkg::RESP_DECERR, resp);
		chk("unmapped_data", 32'h0, q);
		@(posedge CLK);
		BYTEENABLE <= 4'h0;
		bus(1'b1, wdg_pkg::CTRL_ADDR, 8'hff);
		BYTEENABLE <= 4'hf;
		bus(1'b0, wdg_pkg::CTRL_ADDR, 8'h00);
		chk("masked_write", 32'h7f, q);
		idle(300);
		bus(1'b0, wdg_pkg::CTRL_ADDR, 8'h00);
		q2 = q;
		idle(8 * DIV);
		bus(1'b0, wdg_pkg::CTRL_ADDR, 8'h00);
		chk("free_run", 1, 32'(q2 - q >= 7 && q2 - q <= 9));
		bus(1'b0, wdg_pkg::CTRL_ADDR, 8'h00);
		q2 = q;
		CE <= 1'b0;
		repeat (4 * DIV) @(posedge CLK);
		CE <= 1'b1;
		bus(1'b0, wdg_pkg::CTRL_ADDR, 8'h00);
		chk("ce_freeze", 1, 32'(q2 - q <= 1));
		bus(1'b1, wdg_pkg::CTRL_ADDR, 8'h41);
		idle(4 * DIV);
		chk("inactive_no_fire", 0, lows);
		for (int i = 0; i < 6; i++) begin
			r = xs();
			// keep two steps above the top bit so no rollover lands inside the loop
			r[0] = 1'b1;
			bus(1'b1, wdg_pkg::CTRL_ADDR, {(i == 0) | r[7], 1'b1, r[5:0]});
			bus(1'b0, wdg_pkg::CTRL_ADDR, 8'h00);
			chk("act_sticky", 1, 32'(q[7]));
			chk("load", 1, 32'(q[6:0] == {1'b1, r[5:0]} || q[6:0] == {1'b1, r[5:0]} - 7'h01));
		end
		bus(1'b1, wdg_pkg::CTRL_ADDR, 8'hc2);
		fire(2 * DIV - 2, 3 * DIV + 6);
		bus(1'b0, wdg_pkg::CTRL_ADDR, 8'h00);
		chk("act_cleared", 0, 32'(q[7]));
		bus(1'b1, wdg_pkg::CTRL_ADDR, 8'h80);
		fire(0, 4);
		@(posedge CLK);
		HW_WATCHDOG <= 1'b1;
		bus(1'b1, wdg_pkg::CTRL_ADDR, 8'h42);
		fire(2 * DIV - 2, 3 * DIV + 6);
		HW_WATCHDOG <= 1'b0;
		HALT_RESET_OPTION <= 1'b1;
		pulse(3'b100);
		fire(0, 4);
		HALT_RESET_OPTION <= 1'b0;
		RTC_IRQ_ENABLE <= 1'b1;
		bus(1'b1, wdg_pkg::CTRL_ADDR, 8'hff);
		pulse(3'b100);
		bus(1'b0, wdg_pkg::CTRL_ADDR, 8'h00);
		q2 = q;
		idle(4 * DIV);
		bus(1'b0, wdg_pkg::CTRL_ADDR, 8'h00);
		chk("active_halt_frozen", q2, q);
		chk("halted", 1, 32'(HALTED === 1'b1));
		pulse(3'b010);
		idle(2 * DIV + 4);
		bus(1'b0, wdg_pkg::CTRL_ADDR, 8'h00);
		chk("wake_counts", 1, 32'(q < q2));
		RTC_IRQ_ENABLE <= 1'b0;
		bus(1'b1, wdg_pkg::CTRL_ADDR, 8'hc2);
		pulse(3'b100);
		idle(4 * DIV);
		chk("halt_no_fire", 0, lows);
		bus(1'b0, wdg_pkg::CTRL_ADDR, 8'h00);
		chk("halt_one_step", 1, 32'(q == 32'hc1 || q == 32'hc0));
		WAKE_DELAY_LONG <= 1'b1;
		pulse(3'b001);
		fire(wdg_pkg::WAKE_LONG_CYC, wdg_pkg::WAKE_LONG_CYC + 2 * DIV + 8);
		repeat (wdg_pkg::WAKE_LONG_CYC) @(posedge CLK);
		bus(1'b1, wdg_pkg::CTRL_ADDR, 8'hff);
		pulse(3'b100);
		@(posedge CLK);
		chk("plain_halted", 1, 32'(HALTED));
		RESET <= 1'b1;
		repeat (2) @(posedge CLK);
		RESET <= 1'b0;
		bus(1'b0, wdg_pkg::CTRL_ADDR, 8'h00);
		chk("halt_reset_image", 32'h7f, q);
		chk("halt_reset_awake", 0, 32'(HALTED));
		stop_test();
	end
endmodule
